// ### rtl/sdram_cmd_pkg.sv
// constants and types for the sdram command, refresh and power block
// ===========================================================================
package sdram_cmd_pkg;
    // =======================================================================
    // geometry
    localparam int ROW_W      = 12;
    localparam int COL_W      = 9;
    localparam int DQ_W       = 32;
    localparam int BM_W       = 4;
    localparam int LAT_W      = 3;
    localparam int LEN_W      = 10;
    // =======================================================================
    // mode field positions and reset values
    localparam int MODE_LEN_LSB = 0;
    localparam int MODE_LAT_LSB = 4;
    localparam logic [LAT_W-1:0] LAT_RESET = 3'h2;
    localparam logic [2:0]       BL_RESET  = 3'h0;
    localparam logic [2:0]       BL_FULL   = 3'h7;
    localparam logic [LEN_W-1:0] FULL_PAGE_LEN = 10'h200;
    localparam logic [ROW_W-1:0] ROW_RESET = 12'h000;
    // =======================================================================
    // timing
    localparam int CLK_NS      = 25;
    localparam int ROW_CYCLE_NS = 70;
    localparam int ROW_CYCLE_CYC = (ROW_CYCLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SELF_REF_NS  = 15600;
    localparam int SELF_REF_CYC = SELF_REF_NS / CLK_NS;
    localparam int CNT_W        = 10;
    // =======================================================================
    // command encodings {ras, cas, we}, active low
    localparam logic [2:0] ENC_NOP   = 3'h7;
    localparam logic [2:0] ENC_STOP  = 3'h6;
    localparam logic [2:0] ENC_READ  = 3'h5;
    localparam logic [2:0] ENC_WRITE = 3'h4;
    localparam logic [2:0] ENC_ACT   = 3'h3;
    localparam logic [2:0] ENC_PRE   = 3'h2;
    localparam logic [2:0] ENC_REF   = 3'h1;
    localparam logic [2:0] ENC_MODE  = 3'h0;
    // device state, one-hot
    typedef enum logic [5:0] {
        ST_IDLE    = 6'h01,
        ST_BURST   = 6'h02,
        ST_REFRESH = 6'h04,
        ST_SELF    = 6'h08,
        ST_POWER   = 6'h10,
        ST_DRAIN   = 6'h20
    } dev_state_t;
endpackage : sdram_cmd_pkg

// ### rtl/sdram_cmd_if.sv
// sampled command bundle passed from the decoder to the state machine
interface sdram_cmd_if;
    import sdram_cmd_pkg::*;
    logic             sel;      // chip selected this edge
    logic             gate;     // sampled clock-gate level
    logic             gate_d;   // clock-gate level one edge earlier
    logic             is_nop;   // selected no-operation
    logic             is_stop;  // burst stop
    logic             is_read;  // read command
    logic             is_write; // write command
    logic             is_ref;   // refresh encoding
    logic             is_mode;  // mode register set
    logic             ap;       // auto precharge flag on access
    logic [ROW_W-1:0] addr;     // sampled address
    logic [BM_W-1:0]  bmask;    // sampled byte mask
    modport src (output sel, gate, gate_d, is_nop, is_stop, is_read,
                 is_write, is_ref, is_mode, ap, addr, bmask);
    modport dst (input  sel, gate, gate_d, is_nop, is_stop, is_read,
                 is_write, is_ref, is_mode, ap, addr, bmask);
endinterface : sdram_cmd_if

// ### rtl/sdram_cmd_decode.sv
// input sampler and command decoder
module sdram_cmd_decode
    import sdram_cmd_pkg::*;
(
    input  wire logic             i_sys_clk, // system clock
    input  wire logic             i_nrst,    // sync reset, active low
    input  wire logic             i_cs_n,    // chip select pin
    input  wire logic             i_ras_n,   // row strobe pin
    input  wire logic             i_cas_n,   // column strobe pin
    input  wire logic             i_we_n,    // write strobe pin
    input  wire logic             i_cke,     // clock-gate pin
    input  wire logic [ROW_W-1:0] i_addr,    // address pins
    input  wire logic [BM_W-1:0]  i_bmask,   // byte-mask pins
    sdram_cmd_if.src              cmd        // decoded command out
);
    // =======================================================================
    // two-stage synchronisers; stage one feeds only stage two
    logic [ROW_W+BM_W+4:0] meta;   // first stage
    logic [ROW_W+BM_W+4:0] samp;   // second stage
    logic                  gate_q; // gate one edge earlier
    // sample on rising edge only
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            meta   <= '1;
            samp   <= '1;
            gate_q <= 1'b1;
        end else begin
            meta   <= {i_cs_n, i_ras_n, i_cas_n, i_we_n, i_cke,
                       i_addr, i_bmask};
            samp   <= meta;
            gate_q <= samp[ROW_W+BM_W];
        end
    end
    // =======================================================================
    // decode: nothing is decoded while select is high
    wire       cs_n_s = samp[ROW_W+BM_W+4];
    wire [2:0] enc    = samp[ROW_W+BM_W+3:ROW_W+BM_W+1];
    assign cmd.sel      = !cs_n_s;
    assign cmd.gate     = samp[ROW_W+BM_W];
    assign cmd.gate_d   = gate_q;
    assign cmd.is_nop   = cmd.sel && enc == ENC_NOP;
    assign cmd.is_stop  = cmd.sel && enc == ENC_STOP;
    assign cmd.is_read  = cmd.sel && enc == ENC_READ;
    assign cmd.is_write = cmd.sel && enc == ENC_WRITE;
    assign cmd.is_ref   = cmd.sel && enc == ENC_REF;
    assign cmd.is_mode  = cmd.sel && enc == ENC_MODE;
    assign cmd.ap       = samp[BM_W+10];
    assign cmd.addr     = samp[ROW_W+BM_W-1:BM_W];
    assign cmd.bmask    = samp[BM_W-1:0];

    // deselect must never yield a nop, stop or refresh
    a_desel_quiet: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        cs_n_s |-> !(cmd.is_nop || cmd.is_stop || cmd.is_ref))
        else $error("command decoded while deselected");
endmodule : sdram_cmd_decode

// ### rtl/sdram_cmd_core.sv
// command, refresh and power state handling of the sdram device
module sdram_cmd_core
    import sdram_cmd_pkg::*;
(
    input  wire logic             i_sys_clk,   // system clock
    input  wire logic             i_nrst,      // sync reset, active low
    input  wire logic             i_cs_n,      // chip select pin
    input  wire logic             i_ras_n,     // row strobe pin
    input  wire logic             i_cas_n,     // column strobe pin
    input  wire logic             i_we_n,      // write strobe pin
    input  wire logic             i_cke,       // clock-gate pin
    input  wire logic [ROW_W-1:0] i_addr,      // address pins
    input  wire logic [BM_W-1:0]  i_bmask,     // byte-mask pins
    input  wire logic [DQ_W-1:0]  i_dq,        // data bus in
    input  wire logic [DQ_W-1:0]  i_rd_data,   // array read word
    output logic      [DQ_W-1:0]  o_dq,        // data bus out
    output logic      [BM_W-1:0]  o_dq_oe,     // per-byte drive enable
    output logic      [DQ_W-1:0]  o_wr_data,   // word toward array
    output logic      [BM_W-1:0]  o_wr_be,     // write byte enables
    output logic                  o_rd_req,    // array read strobe
    output logic                  o_ref_go,    // refresh row pulse
    output logic      [ROW_W-1:0] o_ref_row,   // row being refreshed
    output logic                  o_self_ref,  // in self refresh
    output logic                  o_powerdown, // buffers off
    output logic                  o_suspend,   // internal clock masked
    output logic      [LAT_W-1:0] o_read_lat   // programmed latency
);
    sdram_cmd_if cmd ();
    // =======================================================================
    // input decoder
    sdram_cmd_decode u_dec (
        .i_sys_clk (i_sys_clk),
        .i_nrst    (i_nrst),
        .i_cs_n    (i_cs_n),
        .i_ras_n   (i_ras_n),
        .i_cas_n   (i_cas_n),
        .i_we_n    (i_we_n),
        .i_cke     (i_cke),
        .i_addr    (i_addr),
        .i_bmask   (i_bmask),
        .cmd       (cmd)
    );
    // =======================================================================
    // state
    dev_state_t       state;       // present state
    dev_state_t       next_state;  // next state
    logic [LAT_W-1:0] lat;         // read latency
    logic [2:0]       blen;        // burst length code
    logic             bur_rd;      // burst is a read
    logic             bur_ap;      // burst carries auto precharge
    logic [LEN_W-1:0] bur_left;    // words left in burst
    logic [CNT_W-1:0] cnt;         // refresh busy / self timer
    logic [ROW_W-1:0] ref_row;     // internal refresh counter
    logic [LAT_W-1:0] drain;       // read data still in flight
    logic [LAT_W:0]   rd_pipe_v [0:7]; // read word in flight, bit 0
    logic [DQ_W-1:0]  dq_meta;     // write data, first stage
    logic [DQ_W-1:0]  dq_samp;     // write data, in step with command
    // =======================================================================
    // decoding of the events
    wire gate_fall  = cmd.gate_d && !cmd.gate;
    wire suspended  = !cmd.gate_d;            // mask from next cycle
    wire ref_auto   = state == ST_IDLE && cmd.is_ref && cmd.gate
                      && cmd.gate_d;
    wire ref_self   = state == ST_IDLE && cmd.is_ref && !cmd.gate;
    wire stop_ok    = cmd.is_stop && !bur_ap;
    wire start_bur  = (cmd.is_read || cmd.is_write) && !suspended;
    wire [LEN_W-1:0] len_words = (blen == BL_FULL) ? FULL_PAGE_LEN :
                      LEN_W'(1) << blen[1:0];
    wire ref_tick   = (state == ST_REFRESH && cnt == '0) ||
                      (state == ST_SELF && cnt == '0);
    wire rd_word    = state == ST_BURST && bur_rd && !suspended;
    // the command cycle itself carries the first read word
    wire rd_first   = state == ST_IDLE && cmd.is_read && !suspended;
    wire rd_now     = rd_word || rd_first;
    // a one-word access is done in its own command cycle
    wire multi_word = len_words != LEN_W'(1);
    // =======================================================================
    // next state
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (ref_auto)
                    next_state = ST_REFRESH;
                else if (ref_self)
                    next_state = ST_SELF;
                else if (gate_fall)
                    next_state = ST_POWER;
                else if (start_bur && multi_word)
                    next_state = ST_BURST;
            end
            ST_BURST: begin
                if (suspended)
                    next_state = ST_BURST;      // hold intact
                else if (start_bur)
                    next_state = multi_word ? ST_BURST : ST_IDLE;
                else if (stop_ok || bur_left <= LEN_W'(1))
                    next_state = bur_rd ? ST_DRAIN : ST_IDLE;
            end
            ST_DRAIN: begin
                if (drain == '0)
                    next_state = ST_IDLE;
            end
            ST_REFRESH: begin
                if (cnt == '0)
                    next_state = ST_IDLE;
            end
            ST_SELF: begin
                if (cmd.gate && (!cmd.sel || cmd.is_nop))
                    next_state = ST_IDLE;       // exit encoding
            end
            ST_POWER: begin
                if (cmd.gate)
                    next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
    end
    // =======================================================================
    // main sequential process
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            state    <= ST_IDLE;
            lat      <= LAT_RESET;
            blen     <= BL_RESET;
            bur_rd   <= 1'b0;
            bur_ap   <= 1'b0;
            bur_left <= '0;
            cnt      <= '0;
            drain    <= '0;
        end else begin
            state <= next_state;
            // mode register only while idle
            if (state == ST_IDLE && cmd.is_mode && !suspended) begin
                lat  <= cmd.addr[MODE_LAT_LSB +: LAT_W];
                blen <= cmd.addr[MODE_LEN_LSB +: 3];
            end
            // burst bookkeeping frozen while suspended
            if (start_bur && (state == ST_IDLE || state == ST_BURST)) begin
                bur_rd   <= cmd.is_read;
                bur_ap   <= cmd.ap;
                // the first word went out with the command itself
                bur_left <= len_words - LEN_W'(1);
            end else if (state == ST_BURST && !suspended) begin
                bur_left <= (blen == BL_FULL) ? bur_left
                                              : bur_left - LEN_W'(1);
            end
            if (state == ST_BURST && next_state == ST_DRAIN)
                drain <= lat - LAT_W'(1);
            else if (state == ST_DRAIN && drain != '0)
                drain <= drain - LAT_W'(1);
            // busy timer for refresh row cycle and self refresh rate
            if (next_state == ST_REFRESH && state == ST_IDLE)
                cnt <= CNT_W'(ROW_CYCLE_CYC - 1);
            else if (next_state == ST_SELF && state == ST_IDLE)
                cnt <= CNT_W'(SELF_REF_CYC - 1);
            else if (state == ST_SELF && cnt == '0)
                cnt <= CNT_W'(SELF_REF_CYC - 1);
            else if (cnt != '0)
                cnt <= cnt - CNT_W'(1);
        end
    end
    // =======================================================================
    // refresh row counter, bumped after each refresh row
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst)
            ref_row <= ROW_RESET;
        else if (ref_tick)
            ref_row <= ref_row + ROW_W'(1);
    end
    // =======================================================================
    // read data pipe: one slot per cycle of latency; the byte mask is
    // applied at the output stage, so it needs no slot of its own
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            for (int i = 0; i < 8; i++) begin
                rd_pipe_v[i] <= '0;
            end
        end else begin
            rd_pipe_v[0] <= {3'h0, rd_now};
            for (int i = 1; i < 8; i++) begin
                rd_pipe_v[i] <= rd_pipe_v[i-1];
            end
        end
    end
    // =======================================================================
    // write data pins pass two stages, in step with the command pins
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            dq_meta <= '0;
            dq_samp <= '0;
        end else begin
            dq_meta <= i_dq;
            dq_samp <= dq_meta;
        end
    end
    wire [2:0] tap       = lat - 3'h2;
    wire       out_valid = rd_pipe_v[tap][0] && !o_powerdown;
    // =======================================================================
    // outputs: data and strobes from flip-flops, status levels decoded from them
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            o_dq      <= '0;
            o_dq_oe   <= '0;
            o_wr_data <= '0;
            o_wr_be   <= '0;
            o_rd_req  <= 1'b0;
            o_ref_go  <= 1'b0;
        end else begin
            o_dq      <= i_rd_data;
            // mask high turns that byte's drivers off
            o_dq_oe   <= out_valid ? ~cmd.bmask : '0;
            o_wr_data <= dq_samp;
            o_wr_be   <= (!suspended && ((state == ST_BURST && !bur_rd)
                          || (cmd.is_write && state == ST_IDLE)))
                         ? ~cmd.bmask : '0;
            o_rd_req  <= rd_now;
            o_ref_go  <= ref_tick;
        end
    end
    assign o_ref_row   = ref_row;
    assign o_self_ref  = state == ST_SELF;
    assign o_powerdown = state == ST_POWER;
    assign o_suspend   = state == ST_BURST && suspended;
    assign o_read_lat  = lat;

    // =======================================================================
    // checks
    a_ref_busy: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        state == ST_IDLE && ref_auto |=> state == ST_REFRESH [*2])
        else $error("refresh busy window too short");
    a_self_enter: assert property (@(posedge i_sys_clk)
        disable iff (!i_nrst) ref_self |=> o_self_ref)
        else $error("self refresh not entered");
    a_stop_ap_kept: assert property (@(posedge i_sys_clk)
        disable iff (!i_nrst) state == ST_BURST && bur_ap && cmd.is_stop
        && !suspended && bur_left > LEN_W'(1) && !start_bur
        |=> state == ST_BURST)
        else $error("stop honoured on auto precharge burst");
    a_stop_ends: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        state == ST_BURST && stop_ok && !suspended && !start_bur
        |=> state != ST_BURST)
        else $error("burst stop ignored");
    a_drain_len: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        state == ST_BURST && next_state == ST_DRAIN
        |=> ##[0:7] state == ST_IDLE)
        else $error("read drain too long");
    a_susp_hold: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        o_suspend |=> $stable(bur_left) || start_bur)
        else $error("burst moved while suspended");
    a_pd_enter: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        state == ST_IDLE && gate_fall && !ref_self |=> o_powerdown)
        else $error("power-down not entered");
    a_pd_exit: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        o_powerdown && cmd.gate |=> !o_powerdown)
        else $error("power-down not left");
    a_mask_read: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        !out_valid |=> o_dq_oe == '0)
        else $error("drivers on without read data");
endmodule : sdram_cmd_core

// ### testbench/sdram_ctrl_model.sv
// memory controller model that drives the sdram command pins
module sdram_ctrl_model
    import sdram_cmd_pkg::*;
(
    input  wire logic             i_sys_clk, // system clock
    output logic                  o_cs_n,    // chip select
    output logic      [2:0]       o_cmd,     // {ras, cas, we}
    output logic                  o_cke,     // clock gate
    output logic      [ROW_W-1:0] o_addr,    // address
    output logic      [BM_W-1:0]  o_bmask,   // byte mask, held
    output logic      [DQ_W-1:0]  o_dq       // write data
);
    timeunit 1ns;
    timeprecision 100ps;
    // =======================================================================
    // power-up: deselected with the clock running
    initial begin
        {o_cs_n, o_cmd, o_cke} = 5'h1F;
        o_addr = 12'h000;
        o_bmask = 4'h0;
        o_dq = 32'h0000_0000;
    end
    // =======================================================================
    // one command, then nops; the waits keep the controller's own timing
    task automatic issue(
        input logic             cs_n, // deselect when high
        input logic [2:0]       enc,  // command encoding
        input logic             cke,  // clock-gate level
        input logic [ROW_W-1:0] addr, // address
        input logic [BM_W-1:0]  bm,   // byte mask
        input logic [DQ_W-1:0]  dq);  // write data
        logic waking; // gate rises with this command
        waking = cke && !o_cke;
        if (waking) begin // gate goes high a cycle before any command
            @(posedge i_sys_clk);
            o_cke <= 1'b1;
        end
        @(posedge i_sys_clk);
        {o_cs_n, o_cmd} <= {cs_n, enc};
        o_cke <= cke;
        o_addr <= addr;
        o_bmask <= bm;
        o_dq <= dq;
        @(posedge i_sys_clk);
        o_cmd <= ENC_NOP;
        o_addr <= ~addr; // released lines must not look held
        o_dq <= ~dq;
        if (waking || (!cs_n && enc == ENC_REF && cke)) begin
            repeat (ROW_CYCLE_CYC + 1) @(posedge i_sys_clk);
        end
    endtask : issue
endmodule : sdram_ctrl_model

// ### testbench/sdram_command_refresh_power_tb_top.sv
// self-checking bench for the sdram command, refresh and power block
module sdram_command_refresh_power_tb_top;
    import sdram_cmd_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic             sys_clk;   // 40 MHz clock
    logic             nrst;      // sync reset, active low
    logic             cs_n;      // chip select from model
    logic [2:0]       cmd;       // {ras, cas, we} from model
    logic             cke;       // clock gate from model
    logic [ROW_W-1:0] addr;      // address from model
    logic [BM_W-1:0]  bmask;     // byte mask from model
    logic [DQ_W-1:0]  dq_in;     // write data from model
    logic [DQ_W-1:0]  rd_data;   // array word offered to the block
    logic [DQ_W-1:0]  dq_out;    // read data out
    logic [BM_W-1:0]  dq_oe;     // per-byte drive enable
    logic [DQ_W-1:0]  wr_data;   // word toward array
    logic [BM_W-1:0]  wr_be;     // write byte enables
    logic             rd_req;    // array read strobe
    logic             ref_go;    // refresh pulse
    logic [ROW_W-1:0] ref_row;   // refresh counter
    logic             self_ref;  // self refresh level
    logic             powerdown; // power-down level
    logic             suspend;   // clock suspend level
    logic [LAT_W-1:0] read_lat;  // programmed latency
    int               bad_count; // mismatches
    int               compares;  // comparisons made
    int               pulses;    // refresh pulses seen
    int               reads;     // array read strobes seen
    int               n;         // bounded wait counter
    // =======================================================================
    // clock, refresh pulse counter and array read strobe counter
    initial sys_clk = 1'b0;
    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (ref_go === 1'b1) pulses <= pulses + 1;
    always @(posedge sys_clk) if (rd_req === 1'b1) reads <= reads + 1;
    // =======================================================================
    // far side and block under test
    sdram_ctrl_model i_sdram_ctrl_model (.i_sys_clk(sys_clk), .o_cs_n(cs_n),
        .o_cmd(cmd), .o_cke(cke), .o_addr(addr), .o_bmask(bmask),
        .o_dq(dq_in));
    sdram_cmd_core i_sdram_cmd_core (.i_sys_clk(sys_clk), .i_nrst(nrst),
        .i_cs_n(cs_n), .i_ras_n(cmd[2]), .i_cas_n(cmd[1]), .i_we_n(cmd[0]),
        .i_cke(cke), .i_addr(addr), .i_bmask(bmask), .i_dq(dq_in),
        .i_rd_data(rd_data), .o_dq(dq_out), .o_dq_oe(dq_oe),
        .o_wr_data(wr_data), .o_wr_be(wr_be), .o_rd_req(rd_req),
        .o_ref_go(ref_go), .o_ref_row(ref_row), .o_self_ref(self_ref),
        .o_powerdown(powerdown), .o_suspend(suspend), .o_read_lat(read_lat));
    // =======================================================================
    // shared helpers
    task automatic check(input logic [DQ_W-1:0] seen,
                         input logic [DQ_W-1:0] exp, input string what);
        compares++;
        if (seen !== exp) begin // report at once
            bad_count++;
            $display("ERROR %0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask : tick
    task automatic cmd_go(input logic c, input logic [2:0] e, input logic k,
                          input logic [ROW_W-1:0] a, input logic [BM_W-1:0] m);
        i_sdram_ctrl_model.issue(c, e, k, a, m, 32'hA5A5_0F0F);
    endtask : cmd_go
    task automatic wait_oe;
        for (n = 0; n < 12 && dq_oe === 4'h0; n++) tick(1);
    endtask : wait_oe
    // =======================================================================
    // scenarios
    task automatic t_idle; // deselected refresh and selected nop do nothing
        cmd_go(1'b1, ENC_REF, 1'b1, 12'h000, 4'h0);
        cmd_go(1'b0, ENC_NOP, 1'b1, 12'h000, 4'h0);
        tick(8);
        check(pulses, 0, "no refresh when idle");
        check({self_ref, powerdown, suspend}, 0, "idle levels");
    endtask : t_idle
    task automatic t_refresh; // two refreshes, address ignored
        cmd_go(1'b0, ENC_REF, 1'b1, 12'hFFF, 4'h0);
        cmd_go(1'b0, ENC_REF, 1'b1, 12'h555, 4'h0);
        tick(8);
        check(pulses, 2, "refresh pulses");
        check(ref_row, 12'h002, "refresh row count");
    endtask : t_refresh
    task automatic t_self; // refresh, enter, ignore a mode set, leave
        cmd_go(1'b0, ENC_REF, 1'b1, 12'h000, 4'h0);
        cmd_go(1'b0, ENC_REF, 1'b0, 12'h000, 4'h0);
        tick(4);
        check(self_ref, 1'b1, "self refresh entry");
        cmd_go(1'b0, ENC_MODE, 1'b0, 12'h030, 4'h0);
        tick(4);
        check(read_lat, 3'h2, "inputs ignored in self refresh");
        tick(SELF_REF_CYC);
        check(ref_row, 12'h004, "self refresh keeps refreshing");
        cmd_go(1'b1, ENC_NOP, 1'b1, 12'h000, 4'h0);
        tick(2);
        check(self_ref, 1'b0, "self refresh exit");
        cmd_go(1'b0, ENC_REF, 1'b1, 12'h000, 4'h0);
        tick(8);
        check(ref_row, 12'h005, "refresh after self refresh");
    endtask : t_self
    task automatic t_power; // gate low while idle, then back
        cmd_go(1'b1, ENC_NOP, 1'b0, 12'h000, 4'h0);
        tick(4);
        check(powerdown, 1'b1, "power-down entry");
        check(suspend, 1'b0, "no suspend when idle");
        cmd_go(1'b1, ENC_NOP, 1'b1, 12'h000, 4'h0);
        tick(2);
        check(powerdown, 1'b0, "power-down exit");
    endtask : t_power
    task automatic t_access; // latency 3, masked write and read
        cmd_go(1'b0, ENC_MODE, 1'b1, 12'h030, 4'h0);
        tick(4);
        check(read_lat, 3'h3, "latency field");
        cmd_go(1'b0, ENC_WRITE, 1'b1, 12'h000, 4'h5);
        for (n = 0; n < 12 && wr_be === 4'h0; n++) tick(1);
        check(wr_be, 4'hA, "write byte enables");
        check(wr_data, 32'hA5A5_0F0F, "write word");
        cmd_go(1'b0, ENC_READ, 1'b1, 12'h000, 4'h3);
        wait_oe;
        check(n, 4, "read latency");
        check(dq_oe, 4'hC, "read drive enables");
        check(dq_out, 32'h1234_5678, "read word");
        tick(6);
        check(reads, 1, "one array read for one word");
    endtask : t_access
    task automatic t_suspend_stop; // full page read, suspend, stop
        cmd_go(1'b0, ENC_MODE, 1'b1, 12'h027, 4'h0);
        cmd_go(1'b0, ENC_READ, 1'b1, 12'h000, 4'h0);
        wait_oe;
        cmd_go(1'b1, ENC_NOP, 1'b0, 12'h000, 4'h0);
        tick(4);
        check({suspend, powerdown}, 2'h2, "suspend in burst");
        cmd_go(1'b1, ENC_NOP, 1'b1, 12'h000, 4'h0);
        tick(2);
        check(suspend, 1'b0, "suspend exit");
        check(dq_oe, 4'hF, "burst resumes");
        cmd_go(1'b0, ENC_STOP, 1'b1, 12'h000, 4'h0);
        for (n = 0; n < 12 && dq_oe !== 4'h0; n++) tick(1);
        check(n >= 2 && n <= 6, 1'b1, "read drains after stop");
    endtask : t_suspend_stop
    task automatic t_stop_ap; // stop has no effect on auto precharge
        cmd_go(1'b0, ENC_READ, 1'b1, 12'h400, 4'h0);
        wait_oe;
        cmd_go(1'b0, ENC_STOP, 1'b1, 12'h000, 4'h0);
        tick(10);
        check(dq_oe, 4'hF, "stop ignored");
    endtask : t_stop_ap
    // =======================================================================
    // verdict, reached from the main sequence or the watchdog
    task automatic wrap_up;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    initial begin // watchdog, well beyond the roughly 800 cycles needed
        #(25 * 5000);
        bad_count++;
        wrap_up;
    end
    initial begin // main sequence
        nrst = 1'b0;
        rd_data = 32'h1234_5678;
        bad_count = 0;
        compares = 0;
        pulses = 0;
        reads = 0;
        repeat (5) @(posedge sys_clk);
        nrst <= 1'b1;
        tick(1);
        check(read_lat, 3'h2, "latency after reset");
        check(ref_row, 12'h000, "row after reset");
        t_idle;
        t_refresh;
        t_self;
        t_power;
        t_access;
        t_suspend_stop;
        t_stop_ap;
        wrap_up;
    end
endmodule : sdram_command_refresh_power_tb_top
